// [hw/xcbt_regs.vh]
/*
 * Constants of the board-level chain test block: chain width, strap
 * positions inside the chain vector and the one-hot mode codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef XCBT_REGS_VH
`define XCBT_REGS_VH

// pins on the chain: every signal pin but the reset and the chain output
`define XCBT_CHAIN_W 90
// strap positions inside the chain input vector
`define XCBT_IDX_FRAME_N 0
`define XCBT_IDX_LAD0 1
// one-hot mode codes
`define XCBT_ST_W 4
`define XCBT_ST_NORMAL 4'h1
`define XCBT_ST_NORMAL_RST 4'h2
`define XCBT_ST_TEST 4'h4
`define XCBT_ST_TEST_RST 4'h8
// reset values
`define XCBT_RST_LEVEL 1'b0
// cycles after a supply reset before the filtered host reset is trusted
`define XCBT_SETTLE_CYC 3'h5

`endif

// [hw/xcbt_pin_filter.v]
/*
 * Input conditioner for a group of pins: three flip-flops per bit and
 * a filtered level that follows once the second and third agree.
 * Assumes the pins are asynchronous to the core clock.
 */
`timescale 1ns/1ns
module xcbt_pin_filter #(
  parameter WIDTH = 1
) (
  input wire i_clk,
  input wire i_srst,
  input wire [WIDTH-1:0] i_pin,
  output wire [WIDTH-1:0] o_level
);
  reg [WIDTH-1:0] s1_q;
  reg [WIDTH-1:0] s2_q;
  reg [WIDTH-1:0] s3_q;
  reg [WIDTH-1:0] lvl_q;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge i_clk) begin
        if (i_srst) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
          s3_q[g] <= 1'b0;
          lvl_q[g] <= 1'b0;
        end else begin
          // s1 is read only by s2: metastability stays in one stage
          s1_q[g] <= i_pin[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            lvl_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  assign o_level = lvl_q;
endmodule

// [hw/xcbt_board_test.v]
/*
 * Board connectivity chain test. Enters and leaves test mode on the
 * rising edge of the host reset pin according to two strap pins and
 * then drives the parity of all chain pins on the power event pin.
 * Assumes I_SRST is the main supply power-on reset and that the pad
 * ring resolves the pin levels from the output enables.
 */
`timescale 1ns/1ns
`include "xcbt_regs.vh"
module xcbt_board_test #(
  parameter CHAIN_W = `XCBT_CHAIN_W
) (
  input wire I_CORE_CLK,
  input wire I_SRST,
  input wire I_HOST_RESET_N,
  input wire [CHAIN_W-1:0] I_PIN_IN,
  input wire [CHAIN_W-1:0] I_NORM_PIN_OUT,
  input wire [CHAIN_W-1:0] I_NORM_PIN_OE,
  input wire I_NORM_POWER_EVENT_OUT_N,
  input wire I_NORM_POWER_EVENT_OE,
  output wire [CHAIN_W-1:0] O_PIN_OUT,
  output wire [CHAIN_W-1:0] O_PIN_OE,
  output wire O_POWER_EVENT_OUT_N,
  output wire O_POWER_EVENT_OE,
  output wire O_TEST_MODE
);
  wire [CHAIN_W:0] filt_lvl;
  wire [CHAIN_W-1:0] chain_lvl;
  wire host_rst_lvl;
  wire rst_rise;
  wire straps_low;
  wire in_test;
  wire chain_parity;
  wire settle_done;

  reg [2:0] settle_q;
  reg host_rst_prev_q;
  reg [`XCBT_ST_W-1:0] state_q;
  reg [`XCBT_ST_W-1:0] state_d;
  reg [CHAIN_W-1:0] pin_out_q;
  reg [CHAIN_W-1:0] pin_oe_q;
  reg pme_out_n_q;
  reg pme_oe_q;

  // reset pin rides on top of the chain group but never feeds parity
  xcbt_pin_filter #(
    .WIDTH(CHAIN_W + 1)
  ) u_filter (
    .i_clk(I_CORE_CLK),
    .i_srst(I_SRST),
    .i_pin({I_HOST_RESET_N, I_PIN_IN}),
    .o_level(filt_lvl)
  );

  assign chain_lvl = filt_lvl[CHAIN_W-1:0];
  assign host_rst_lvl = filt_lvl[CHAIN_W];

  always @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      host_rst_prev_q <= `XCBT_RST_LEVEL;
    end else begin
      host_rst_prev_q <= host_rst_lvl;
    end
  end

  // filter flops clear to low, which would look like a host reset;
  // a supply reset with the host reset pin already high and both
  // straps low must not fall back into test mode
  always @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      settle_q <= 3'h0;
    end else if (!settle_done) begin
      settle_q <= settle_q + 3'h1;
    end
  end

  assign settle_done = (settle_q == `XCBT_SETTLE_CYC);

  assign rst_rise = host_rst_lvl & ~host_rst_prev_q;
  assign straps_low = ~chain_lvl[`XCBT_IDX_FRAME_N] &
                      ~chain_lvl[`XCBT_IDX_LAD0];

  // mode changes only on a reset rise; other reset motion is ignored
  always @* begin
    state_d = state_q;
    case (state_q)
      `XCBT_ST_NORMAL: begin
        if (~host_rst_lvl) begin
          state_d = `XCBT_ST_NORMAL_RST;
        end
      end
      `XCBT_ST_NORMAL_RST: begin
        if (rst_rise) begin
          if (straps_low) begin
            state_d = `XCBT_ST_TEST;
          end else begin
            state_d = `XCBT_ST_NORMAL;
          end
        end
      end
      `XCBT_ST_TEST: begin
        if (~host_rst_lvl) begin
          state_d = `XCBT_ST_TEST_RST;
        end
      end
      `XCBT_ST_TEST_RST: begin
        if (rst_rise) begin
          if (straps_low) begin
            state_d = `XCBT_ST_TEST;
          end else begin
            state_d = `XCBT_ST_NORMAL;
          end
        end
      end
      default: begin
        state_d = `XCBT_ST_NORMAL;
      end
    endcase
  end

  always @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      state_q <= `XCBT_ST_NORMAL;
    end else if (settle_done) begin
      state_q <= state_d;
    end
  end

  // test mode holds through a later reset low phase until its rise
  assign in_test = state_q[2] | state_q[3];

  // even chain width: all low and all high both give zero
  assign chain_parity = ^chain_lvl;

  always @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      pin_out_q <= {CHAIN_W{1'b0}};
      pin_oe_q <= {CHAIN_W{1'b0}};
      pme_out_n_q <= 1'b1;
      pme_oe_q <= 1'b0;
    end else if (in_test) begin
      pin_out_q <= {CHAIN_W{1'b0}};
      pin_oe_q <= {CHAIN_W{1'b0}};
      pme_out_n_q <= chain_parity;
      pme_oe_q <= 1'b1;
    end else begin
      pin_out_q <= I_NORM_PIN_OUT;
      pin_oe_q <= I_NORM_PIN_OE;
      pme_out_n_q <= I_NORM_POWER_EVENT_OUT_N;
      pme_oe_q <= I_NORM_POWER_EVENT_OE;
    end
  end

  assign O_PIN_OUT = pin_out_q;
  assign O_PIN_OE = pin_oe_q;
  assign O_POWER_EVENT_OUT_N = pme_out_n_q;
  assign O_POWER_EVENT_OE = pme_oe_q;
  assign O_TEST_MODE = in_test;
endmodule

// [bench/xcbt_chk.sv]
/* port checker of the chain test block;
   assumes binding onto xcbt_board_test */
`timescale 1ns/1ns
module xcbt_chk #(parameter CHAIN_W = 90) (
  input wire I_CORE_CLK,
  input wire I_SRST,
  input wire I_HOST_RESET_N,
  input wire [CHAIN_W-1:0] I_PIN_IN,
  input wire I_NORM_POWER_EVENT_OUT_N,
  input wire [CHAIN_W-1:0] O_PIN_OUT,
  input wire [CHAIN_W-1:0] O_PIN_OE,
  input wire O_POWER_EVENT_OUT_N,
  input wire O_POWER_EVENT_OE,
  input wire O_TEST_MODE
);
  default clocking @(posedge I_CORE_CLK);
  endclocking
  default disable iff (I_SRST);
  // seven quiet cycles cover the filter and output flop latency
  sequence quiet;
    (O_TEST_MODE && $stable(I_PIN_IN))[*7];
  endsequence
  a_pins_off:
    assert property (O_TEST_MODE && $past(O_TEST_MODE) |-> !O_PIN_OE &&
      !O_PIN_OUT && O_POWER_EVENT_OE) else $error("drive");
  a_chain_parity:
    assert property (quiet |-> O_POWER_EVENT_OUT_N == ^I_PIN_IN)
      else $error("parity");
  a_reset_excluded:
    assert property (quiet |=> $stable(O_POWER_EVENT_OUT_N))
      else $error("moved");
  a_enter_straps:
    assert property ($rose(O_TEST_MODE) |-> $past(I_PIN_IN[1:0], 3) == 0)
      else $error("entry");
  a_exit_straps:
    assert property ($fell(O_TEST_MODE) && !$past(I_SRST) |->
      $past(I_PIN_IN[1:0], 3) != 0) else $error("exit");
  a_mode_at_rise:
    assert property ($changed(O_TEST_MODE) && !$past(I_SRST) |->
      $past(I_HOST_RESET_N)) else $error("mode");
  a_por_exit:
    assert property (@(posedge I_CORE_CLK) disable iff (1'b0)
      I_SRST |=> !O_TEST_MODE) else $error("por");
  a_normal_pass:
    assert property (!O_TEST_MODE && !$past(O_TEST_MODE) && !$past(I_SRST)
      |-> O_POWER_EVENT_OUT_N == $past(I_NORM_POWER_EVENT_OUT_N))
      else $error("normal");
  cover property ($rose(O_TEST_MODE));
  cover property ($fell(O_TEST_MODE));
  cover property (O_TEST_MODE && O_POWER_EVENT_OUT_N);
endmodule
bind xcbt_board_test xcbt_chk #(.CHAIN_W(CHAIN_W)) xcbt_chk_inst (.*);

// [bench/xcbt_tester.sv]
/* board tester model; assumes one level vector per step */
`timescale 1ns/1ns
module xcbt_tester #(parameter W = 90) (
  input wire [W-1:0] i_drv,
  input wire [W-1:0] i_oe,
  input wire [W-1:0] i_dout,
  output wire [W-1:0] o_pin
);
  // device drive wins, so a stray enable shows as a parity slip
  assign o_pin = i_oe & i_dout | ~i_oe & i_drv;
endmodule

// [bench/xcbt_board_test_tb.sv]
/* bench of the chain test block; assumes the tester model on pins */
`timescale 1ns/1ns
module xcbt_board_test_tb;
  reg clk = 0, srst = 1, hr_n = 0, npe = 1, look = 0;
  reg [89:0] drv = 0, nout = 0, noe = 0, v = 0;
  reg [2:0] q[$];
  wire [89:0] pin, pout, poe;
  wire pe, pe_oe, tm;
  integer error_cnt = 0, num_checks = 0, cyc = 0, i;
  xcbt_board_test xcbt_board_test_inst (.I_CORE_CLK(clk), .I_SRST(srst),
    .I_HOST_RESET_N(hr_n), .I_PIN_IN(pin), .I_NORM_PIN_OUT(nout),
    .I_NORM_PIN_OE(noe), .I_NORM_POWER_EVENT_OUT_N(npe),
    .I_NORM_POWER_EVENT_OE(npe), .O_PIN_OUT(pout), .O_PIN_OE(poe),
    .O_POWER_EVENT_OUT_N(pe), .O_POWER_EVENT_OE(pe_oe), .O_TEST_MODE(tm));
  xcbt_tester xcbt_tester_inst (.i_drv(drv), .i_oe(poe), .i_dout(pout),
    .o_pin(pin));
  initial forever #5 clk = ~clk;
  task end_of_test;
    if (error_cnt == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task cmp(input [2:0] e, input [2:0] g);
    num_checks = num_checks + 1;
    if (g !== e) begin
      error_cnt = error_cnt + 1;
      $display("unexpected %0t %h %h", $time, e, g);
    end
  endtask
  // straps never driven by the device, or entry could not be seen
  task step(input [89:0] s, input h, input m);
    drv = s;
    hr_n = h;
    nout = 90'({3{$urandom}});
    noe = {~nout[89:2], 2'b00};
    npe = 1'($urandom);
    repeat (12) @(negedge clk);
    q.push_back({m, m ? ^s : npe, m | npe});
    look = 1;
    @(negedge clk);
    look = 0;
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (look) cmp(q.pop_front(), {tm, pe, pe_oe});
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      end_of_test;
    end
  end
  initial begin
    i = $urandom(32'h27b9);
    repeat (8) @(negedge clk);
    srst = 0;
    step(v, 0, 0);
    step(v, 1, 1);
    for (i = 89; i >= 0; i = i - 1) begin
      v[i] = 1;
      step(v, 1, 1);
    end
    for (i = 0; i < 90; i = i + 1) begin
      v[i] = 0;
      step(v, 1, 1);
    end
    repeat (6) begin
      v = 90'({3{$urandom}});
      v[1:0] = 0;
      step(v, 0, 1);
      step(v, 1, 1);
    end
    for (i = 1; i < 4; i = i + 1) begin
      v[1:0] = 2'(i);
      step(v, 0, 1);
      step(v, 1, 0);
      step(~v, 1, 0);
      v[1:0] = 0;
      step(v, 0, 0);
      step(v, 1, 1);
    end
    // straps low and host reset high: only the supply reset may exit
    v[1:0] = 0;
    drv = v;
    srst = 1;
    @(negedge clk);
    srst = 0;
    step(v, 1, 0);
    end_of_test;
  end
endmodule
